// File: logic/leib_pkg.sv
package leib_pkg;

  // Clock and timing.
  localparam int CLK_MHZ          = 100;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OVERLONG_MIN_US  = 115;
  localparam int OVERLONG_MAX_US  = 120;
  // The event may fire anywhere in the window, so the earliest point is used.
  localparam int OVERLONG_CYCLES  = OVERLONG_MIN_US * 1000 / CLK_PERIOD_NS;
  localparam int OVERLONG_CNT_W   = 16;

  // Register byte offsets on the APB.
  localparam logic [11:0] OFS_EVENT_SET  = 12'h000;
  localparam logic [11:0] OFS_EVENT_CLR  = 12'h004;
  localparam logic [11:0] OFS_MASK_SET   = 12'h008;
  localparam logic [11:0] OFS_MASK_CLR   = 12'h00C;
  localparam logic [11:0] OFS_LINK_CTRL  = 12'h010;
  localparam logic [11:0] OFS_HALT_CAUSE = 12'h014;

  // Event bit positions inside interrupt_event_reg.
  localparam int BIT_LOCK_FAIL   = 9;
  localparam int BIT_SELFID_DONE = 16;
  localparam int BIT_BUS_INIT    = 17;
  localparam int BIT_PHY_IRQ     = 19;
  localparam int BIT_NEW_CYCLE   = 20;
  localparam int BIT_SEC_WRAP    = 21;
  localparam int BIT_MISSED      = 22;
  localparam int BIT_MISMATCH    = 23;
  localparam int BIT_FATAL       = 24;
  localparam int BIT_OVERLONG    = 25;
  localparam int BIT_PHY_REG     = 26;
  localparam int BIT_MASTER_EN   = 31;

  // Implemented event bits; every other position reads zero.
  localparam logic [31:0] EVENT_VALID = 32'h07FB_0200;
  localparam logic [31:0] MASK_VALID  = 32'h87FB_0200;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // Fields of link_control_reg.
  localparam int          LINK_CM_BIT        = 0;
  localparam int          LINK_HOSTWR_BIT    = 1;
  localparam logic [31:0] LINK_VALID         = 32'h0000_0003;
  localparam logic [31:0] LINK_RESET         = 32'h0000_0000;

  // Edge detector source indices.
  localparam int SRC_LOCK_FAIL = 0;
  localparam int SRC_SELFID    = 1;
  localparam int SRC_BUS_INIT  = 2;
  localparam int SRC_PHY_IRQ   = 3;
  localparam int SRC_CYC_LSB   = 4;
  localparam int SRC_SEC_BIT   = 5;
  localparam int SRC_MISMATCH  = 6;
  localparam int SRC_FATAL     = 7;
  localparam int SRC_PHY_REG   = 8;
  localparam int SRC_N         = 9;

  localparam int CTX_N = 8;

  typedef enum logic {
    OL_IDLE,
    OL_TIMING
  } leib_ol_state_t;

endpackage : leib_pkg

// File: logic/leib_edge_if.sv
`timescale 1ns/10ps
`default_nettype none

interface leib_edge_if #(
  parameter int W = 9
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] change;

  modport src (output level, input rise, input change);
  modport det (input level, output rise, output change);
endinterface : leib_edge_if

`default_nettype wire

// File: logic/leib_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none

module leib_edge_detect
  import leib_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Source levels in, edges out
  leib_edge_if.det  edges
);

  genvar gi;
  generate
    for (gi = 0; gi < SRC_N; gi++) begin : g_edge
      // Each lane keeps its own history bit, so no flop has two writers.
      logic prevLevel;

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          prevLevel <= 1'b0;
        end else begin
          prevLevel <= edges.level[gi];
        end
      end
      assign edges.rise[gi]   = edges.level[gi] & ~prevLevel;
      assign edges.change[gi] = edges.level[gi] ^ prevLevel;
    end
  endgenerate

endmodule : leib_edge_detect

`default_nettype wire

// File: logic/leib_event_bits.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module leib_event_bits
  import leib_pkg::*;
#(
  parameter int unsigned OVERLONG_LIMIT = OVERLONG_CYCLES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Link and PHY condition sources
  input  wire logic             lockRespNoAck,
  input  wire logic             selfidStreamDone,
  input  wire logic             selfidPhase,
  input  wire logic             phyBusReset,
  input  wire logic             phyStatusIrq,
  input  wire logic             cycleCountLsb,
  input  wire logic             secondsBit,
  input  wire logic             cycleStartSeen,
  input  wire logic             cycleStartMismatch,
  input  wire logic             timerFieldsWritten,
  input  wire logic [CTX_N-1:0] contextDead,
  input  wire logic             cycleStartTxBegin,
  input  wire logic             subactionGapEnd,
  input  wire logic             phyRegByteReady,
  // Results
  output var  logic [CTX_N-1:0] ctxIrqBlocked,
  output var  logic             cycleMasterEnable,
  output logic                  irq
);

  function automatic logic isOfs(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction : isOfs

  logic [31:0]          eventReg;
  logic [31:0]          maskReg;
  logic [31:0]          linkReg;
  logic [31:0]          next_eventReg;
  logic [31:0]          next_maskReg;
  logic [31:0]          next_linkReg;
  logic [31:0]          hwSet;
  logic [31:0]          swSet;
  logic [31:0]          swClr;
  logic [31:0]          readMux;
  logic [CTX_N-1:0]     next_ctxIrqBlocked;
  logic                 readHit;
  logic                 seenSinceTick;
  logic                 tickArmed;
  logic                 missedPulse;
  logic                 overlongPulse;
  logic                 stopTiming;
  logic [OVERLONG_CNT_W-1:0] olCount;
  leib_ol_state_t       olState;
  leib_ol_state_t       next_olState;

  leib_edge_if #(.W(SRC_N)) edgeBus ();

  leib_edge_detect u_edge (
    .clk   (clk),
    .reset (reset),
    .edges (edgeBus)
  );

  // Every lane starts from a low history after reset, so a source that is
  // already high when reset ends is taken as a fresh event on the first clock.
  // Source levels, one per edge detector lane.
  assign edgeBus.level[SRC_LOCK_FAIL] = lockRespNoAck;
  assign edgeBus.level[SRC_SELFID]    = selfidStreamDone;
  assign edgeBus.level[SRC_BUS_INIT]  = phyBusReset;
  assign edgeBus.level[SRC_PHY_IRQ]   = phyStatusIrq;
  assign edgeBus.level[SRC_CYC_LSB]   = cycleCountLsb;
  assign edgeBus.level[SRC_SEC_BIT]   = secondsBit;
  assign edgeBus.level[SRC_MISMATCH]  = cycleStartMismatch |
                                        (linkReg[LINK_HOSTWR_BIT] & timerFieldsWritten);
  assign edgeBus.level[SRC_FATAL]     = |contextDead;
  assign edgeBus.level[SRC_PHY_REG]   = phyRegByteReady;

  // Each toggle of the count's low bit is a new cycle, so both edges count.
  wire newCycle    = edgeBus.change[SRC_CYC_LSB];
  wire busInitRise = edgeBus.rise[SRC_BUS_INIT];

  // Hardware set terms; every source but the overlong timer pulse is edge qualified.
  always_comb begin
    hwSet                  = 32'h0000_0000;
    hwSet[BIT_LOCK_FAIL]   = edgeBus.rise[SRC_LOCK_FAIL];
    hwSet[BIT_SELFID_DONE] = edgeBus.rise[SRC_SELFID];
    hwSet[BIT_BUS_INIT]    = busInitRise;
    hwSet[BIT_PHY_IRQ]     = edgeBus.rise[SRC_PHY_IRQ];
    hwSet[BIT_NEW_CYCLE]   = newCycle;
    hwSet[BIT_SEC_WRAP]    = edgeBus.change[SRC_SEC_BIT];
    hwSet[BIT_MISSED]      = missedPulse;
    hwSet[BIT_MISMATCH]    = edgeBus.rise[SRC_MISMATCH];
    hwSet[BIT_FATAL]       = edgeBus.rise[SRC_FATAL];
    hwSet[BIT_OVERLONG]    = overlongPulse;
    hwSet[BIT_PHY_REG]     = edgeBus.rise[SRC_PHY_REG];
  end

  // APB decode. The slave never waits, so every access ends in one access cycle.
  wire access   = psel & penable;
  wire wrAccess = access & pwrite;
  wire hitEvSet = isOfs(paddr, OFS_EVENT_SET);
  wire hitEvClr = isOfs(paddr, OFS_EVENT_CLR);
  wire hitMkSet = isOfs(paddr, OFS_MASK_SET);
  wire hitMkClr = isOfs(paddr, OFS_MASK_CLR);
  wire hitLink  = isOfs(paddr, OFS_LINK_CTRL);
  wire hitHalt  = isOfs(paddr, OFS_HALT_CAUSE);

  // The halt cause alias is read only; a write there is accepted and dropped.
  assign readHit = hitEvSet | hitEvClr | hitMkSet | hitMkClr | hitLink | hitHalt;
  assign pready  = 1'b1;
  assign pslverr = access & ~readHit;

  // Software set and clear, limited to implemented bits.
  assign swSet = (wrAccess & hitEvSet) ? (pwdata & EVENT_VALID) : 32'h0000_0000;
  // Bus reset may not be cleared while self-ID is still in progress.
  assign swClr = (wrAccess & hitEvClr) ?
                 (pwdata & EVENT_VALID & ~({31'h0000_0000, selfidPhase} << BIT_BUS_INIT)) :
                 32'h0000_0000;

  // Set wins over clear so that an event landing on a clear is not lost.
  always_comb begin
    next_eventReg = ((eventReg & ~swClr) | hwSet | swSet) & EVENT_VALID;
    if (hwSet[BIT_BUS_INIT]) begin
      next_eventReg[BIT_SELFID_DONE] = 1'b0;
    end
  end

  // Both mask aliases share one register and read back the same value.
  always_comb begin
    next_maskReg = maskReg;
    if (wrAccess & hitMkSet) begin
      next_maskReg = maskReg | (pwdata & MASK_VALID);
    end else if (wrAccess & hitMkClr) begin
      next_maskReg = maskReg & ~(pwdata & MASK_VALID);
    end
  end

  // The hardware clear of the cycle master enable beats a software write in
  // the same cycle, so a late write cannot keep a runaway master alive.
  always_comb begin
    next_linkReg = linkReg;
    if (wrAccess & hitLink) begin
      next_linkReg = pwdata & LINK_VALID;
    end
    if (overlongPulse) begin
      next_linkReg[LINK_CM_BIT] = 1'b0;
    end
  end

  // Halt causes collect while the fatal bit stands and vanish with it.
  // A context that dies while the bit already stands raises no second fatal
  // event, but it is still collected here.
  always_comb begin
    if (next_eventReg[BIT_FATAL]) begin
      next_ctxIrqBlocked = ctxIrqBlocked | contextDead;
    end else begin
      next_ctxIrqBlocked = {CTX_N{1'b0}};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eventReg      <= EVENT_RESET;
      maskReg       <= MASK_RESET;
      linkReg       <= LINK_RESET;
      ctxIrqBlocked <= {CTX_N{1'b0}};
    end else begin
      eventReg      <= next_eventReg;
      maskReg       <= next_maskReg;
      linkReg       <= next_linkReg;
      ctxIrqBlocked <= next_ctxIrqBlocked;
    end
  end

  assign cycleMasterEnable = linkReg[LINK_CM_BIT];

  // The masked view ignores the master enable, as the clear alias must.
  wire [31:0] maskedEvents = eventReg & maskReg & EVENT_VALID;

  // The master enable gates only the pin, so software can still poll the
  // masked events with interrupts turned off.
  assign irq = maskReg[BIT_MASTER_EN] & (|maskedEvents);

  always_comb begin
    readMux = 32'h0000_0000;
    if (hitEvSet) begin
      readMux = eventReg & EVENT_VALID;
    end else if (hitEvClr) begin
      readMux = maskedEvents;
    end else if (hitMkSet | hitMkClr) begin
      readMux = maskReg & MASK_VALID;
    end else if (hitLink) begin
      readMux = linkReg & LINK_VALID;
    end else if (hitHalt) begin
      readMux = {{(32 - CTX_N){1'b0}}, ctxIrqBlocked};
    end
  end

  // Read data is caught in the setup cycle so prdata comes from a flop.
  // An event that lands between setup and access shows in the next read.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= readMux;
    end
  end

  // Missed cycle watch. The first tick after reset only arms the check,
  // since nothing is known about the cycle before it.
  assign missedPulse = newCycle & tickArmed & ~seenSinceTick & ~cycleStartSeen;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seenSinceTick <= 1'b0;
      tickArmed     <= 1'b0;
    end else if (newCycle) begin
      seenSinceTick <= 1'b0;
      tickArmed     <= 1'b1;
    end else if (cycleStartSeen) begin
      seenSinceTick <= 1'b1;
    end
  end

  // Overlong cycle timer, only live while acting as cycle master.
  // Only the rising edge of bus reset ends the measure; a held level is old news.
  assign stopTiming    = subactionGapEnd | busInitRise;
  assign overlongPulse = (olState == OL_TIMING) & ~stopTiming &
                         (olCount == OVERLONG_CNT_W'(OVERLONG_LIMIT - 1));

  // A second start while the timer runs is ignored; the measure belongs to the
  // start that began it.
  always_comb begin
    case (olState)
      OL_IDLE: begin
        if (cycleStartTxBegin & linkReg[LINK_CM_BIT]) begin
          next_olState = OL_TIMING;
        end else begin
          next_olState = OL_IDLE;
        end
      end
      OL_TIMING: begin
        if (stopTiming | overlongPulse | ~linkReg[LINK_CM_BIT]) begin
          next_olState = OL_IDLE;
        end else begin
          next_olState = OL_TIMING;
        end
      end
      default: begin
        next_olState = OL_IDLE;
      end
    endcase
  end

  // The counter width covers the default limit with room to spare; a limit
  // beyond its range needs a wider counter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      olState <= OL_IDLE;
      olCount <= '0;
    end else begin
      olState <= next_olState;
      if (olState == OL_TIMING) begin
        olCount <= olCount + 1'b1;
      end else begin
        olCount <= '0;
      end
    end
  end

endmodule : leib_event_bits

`default_nettype wire

// File: verification/leib_event_bits_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module leib_event_bits_asserts
  import leib_pkg::*;
#(
  parameter int unsigned OVERLONG_LIMIT = OVERLONG_CYCLES
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Sources and results
  input wire logic             phyBusReset,
  input wire logic [CTX_N-1:0] contextDead,
  input wire logic             cycleStartTxBegin,
  input wire logic             subactionGapEnd,
  input wire logic [CTX_N-1:0] ctxIrqBlocked,
  input wire logic             cycleMasterEnable,
  input wire logic             irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  wire logic acc = psel && penable;
  // Stops on a bus reset level, not its edge, so it never runs ahead of the design.
  int unsigned olCnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      olCnt <= 0;
    else if (cycleStartTxBegin && cycleMasterEnable)
      olCnt <= 1;
    else if (olCnt != 0 && cycleMasterEnable && !subactionGapEnd && !phyBusReset)
      olCnt <= olCnt + 1;
    else
      olCnt <= 0;
  end

  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in a transfer");
  property p_err_phase; pslverr |-> acc; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_unmapped; acc && paddr > OFS_HALT_CAUSE |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_resv_zero;
    acc && !pwrite && paddr <= OFS_EVENT_CLR |-> (prdata & ~EVENT_VALID) == 32'h0000_0000;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved event bit read");
  property p_blocked;
    (ctxIrqBlocked & ~$past(ctxIrqBlocked) & ~($past(contextDead) | $past(contextDead, 2))) == '0;
  endproperty
  a_blocked: assert property (p_blocked) else $error("context blocked without halt");
  property p_ol_clear;
    olCnt == OVERLONG_LIMIT && !subactionGapEnd && !phyBusReset |=> !cycleMasterEnable;
  endproperty
  a_ol_clear: assert property (p_ol_clear) else $error("overlong cycle missed");
  property p_cme_rise;
    $rose(cycleMasterEnable) |-> $past(acc && pwrite && paddr == OFS_LINK_CTRL && pwdata[0]);
  endproperty
  a_cme_rise: assert property (p_cme_rise) else $error("cycle master set by itself");
  property p_master_off;
    acc && pwrite && paddr == OFS_MASK_CLR && pwdata[31] |=> !irq;
  endproperty
  a_master_off: assert property (p_master_off) else $error("irq with master off");

  c_overlong: cover property (olCnt == OVERLONG_LIMIT);
  c_blocked: cover property (ctxIrqBlocked != '0);
  c_unmapped: cover property (pslverr);
endmodule : leib_event_bits_asserts

`default_nettype wire

// File: verification/tb_link_event_interrupt_bits.sv
`timescale 1ns/10ps
`default_nettype none

module tb_link_event_interrupt_bits
  import leib_pkg::*;
;
  localparam int LIM = 20;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq, cme;
  logic        cycLsb, secBit, startSeen, tfw, selPh, txBegin, gapEnd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, ev, mk, lk;
  logic [7:0]  dead, blk;
  logic [5:0]  src;
  int          n_mismatch, compares;
  int          bitOf [6] = '{9, 16, 17, 19, 23, 26};

  leib_event_bits #(.OVERLONG_LIMIT(LIM)) dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lockRespNoAck(src[0]), .selfidStreamDone(src[1]), .selfidPhase(selPh),
    .phyBusReset(src[2]), .phyStatusIrq(src[3]), .cycleCountLsb(cycLsb),
    .secondsBit(secBit), .cycleStartSeen(startSeen), .cycleStartMismatch(src[4]),
    .timerFieldsWritten(tfw), .contextDead(dead), .cycleStartTxBegin(txBegin),
    .subactionGapEnd(gapEnd), .phyRegByteReady(src[5]), .ctxIrqBlocked(blk),
    .cycleMasterEnable(cme), .irq(irq)
  );

  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h, expected %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk(pslverr, a > OFS_HALT_CAUSE);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask : rd

  // The model refuses a clear of the bus reset bit while self-identification runs.
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      OFS_EVENT_SET: ev = ev | (d & EVENT_VALID);
      OFS_EVENT_CLR: ev = ev & ~(d & ~(32'(selPh) << 17));
      OFS_MASK_SET: mk = mk | (d & MASK_VALID);
      OFS_MASK_CLR: mk = mk & ~d;
      OFS_LINK_CTRL: lk = d & LINK_VALID;
      default: ;
    endcase
  endtask : put

  task automatic look();
    rd(OFS_EVENT_SET, ev);
    rd(OFS_EVENT_CLR, ev & mk);
    rd(OFS_MASK_CLR, mk);
    chk(irq, mk[31] && (ev & mk) != 0);
  endtask : look

  task automatic hit(input int i);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
    ev[bitOf[i]] = 1'b1;
    if (i == 2)
      ev[16] = 1'b0;
  endtask : hit

  task automatic tick(input logic seen);
    @(posedge clk);
    startSeen <= seen;
    @(posedge clk);
    startSeen <= 1'b0;
    cycLsb <= ~cycLsb;
    @(posedge clk);
    ev[20] = 1'b1;
    if (!seen)
      ev[22] = 1'b1;
  endtask : tick

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100_000;
    n_mismatch++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, cycLsb, secBit, startSeen, tfw, selPh, txBegin, gapEnd} = '0;
    {paddr, pwdata, src, dead, ev, mk, lk} = '0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    void'($urandom(96138));
    rd(OFS_EVENT_SET, EVENT_RESET);
    rd(OFS_MASK_SET, MASK_RESET);
    rd(OFS_LINK_CTRL, LINK_RESET);
    rd(OFS_HALT_CAUSE, 32'h0000_0000);
    rd(12'h018, 32'h0000_0000);
    $display("test reset done");
    repeat (8) begin
      put(OFS_EVENT_SET, $urandom & 32'hFFFC_FFFF);
      put(OFS_MASK_SET, $urandom);
      look();
      put(OFS_EVENT_CLR, $urandom);
      put(OFS_MASK_CLR, $urandom);
      look();
    end
    put(OFS_EVENT_CLR, 32'hFFFF_FFFF);
    put(OFS_MASK_SET, MASK_VALID);
    $display("test aliases done");
    for (int i = 0; i < 6; i++) begin
      hit(i);
      look();
    end
    src[3] <= 1'b1;
    repeat (3) @(posedge clk);
    put(OFS_EVENT_CLR, 32'h0008_0000);
    look();
    src[3] <= 1'b0;
    tick(1'b1);
    look();
    tick(1'b0);
    look();
    secBit <= 1'b1;
    ev[21] = 1'b1;
    repeat (2) @(posedge clk);
    look();
    hit(2);
    selPh <= 1'b1;
    put(OFS_EVENT_CLR, 32'h0003_0000);
    look();
    selPh <= 1'b0;
    put(OFS_EVENT_CLR, 32'h0002_0000);
    look();
    $display("test sources done");
    put(OFS_LINK_CTRL, 32'h0000_0002);
    put(OFS_EVENT_CLR, 32'h0080_0000);
    tfw <= 1'b1;
    ev[23] = 1'b1;
    repeat (2) @(posedge clk);
    look();
    tfw <= 1'b0;
    dead <= 8'h08;
    ev[24] = 1'b1;
    repeat (3) @(posedge clk);
    look();
    chk(blk, 8'h08);
    rd(OFS_HALT_CAUSE, 32'h0000_0008);
    dead <= 8'h00;
    $display("test halt done");
    put(OFS_LINK_CTRL, 32'h0000_0001);
    // The first start is ended by a gap, the second is left to run over.
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      txBegin <= 1'b1;
      @(posedge clk);
      txBegin <= 1'b0;
      repeat (5) @(posedge clk);
      gapEnd <= (g == 0);
      @(posedge clk);
      gapEnd <= 1'b0;
      repeat (LIM) @(posedge clk);
      if (g == 1) begin
        ev[25] = 1'b1;
        lk[0] = 1'b0;
      end
      chk(cme, lk[0]);
      look();
    end
    rd(OFS_LINK_CTRL, lk);
    put(OFS_MASK_CLR, 32'h8000_0000);
    look();
    $display("test overlong and irq done");
    summarize();
  end
endmodule : tb_link_event_interrupt_bits

bind leib_event_bits leib_event_bits_asserts #(.OVERLONG_LIMIT(OVERLONG_LIMIT)) chk_u (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phyBusReset(phyBusReset), .contextDead(contextDead), .cycleStartTxBegin(cycleStartTxBegin),
  .subactionGapEnd(subactionGapEnd), .ctxIrqBlocked(ctxIrqBlocked),
  .cycleMasterEnable(cycleMasterEnable), .irq(irq)
);

`default_nettype wire
